//--- hw/cbs_bus_sequencer.v
// bus cycle sequencer: read, write and dummy cycles, waits, bus clock,
// interrupt acknowledge, halt, reset; assumes the cpu core issues one
// bus cycle per request and keeps its own program flow otherwise
`timescale 1ns/100ps
`default_nettype none
`include "cbs_regs.vh"
module cbs_bus_sequencer #(
  parameter BANK_W = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire cyc_valid,
  output wire cyc_ready,
  input wire [1:0] cyc_kind,
  input wire [19:0] cyc_addr,
  input wire [7:0] cyc_wdata,
  input wire cyc_internal,
  input wire cyc_last,
  output reg cyc_done,
  output reg [7:0] cyc_rdata,
  output reg [19:0] ext_addr,
  output reg ext_addr_oe,
  input wire [7:0] ext_data_in,
  output reg [7:0] ext_data_out,
  output reg ext_data_oe,
  output reg rd_n,
  output reg wr_n,
  output reg bus_clk,
  input wire wait_req_n,
  input wire irq_req,
  input wire nmi_req,
  input wire [7:0] irq_vector,
  input wire [15:0] sp_in,
  input wire [15:0] af_in,
  input wire ei_pulse,
  input wire di_pulse,
  input wire halt_pulse,
  input wire pc_load,
  input wire [15:0] pc_next,
  output reg [15:0] pc,
  output reg interrupt_enable_flag,
  output reg halted,
  output reg irq_accept,
  input wire bank_load_x,
  input wire bank_load_y,
  input wire [BANK_W-1:0] bank_wdata,
  output reg [BANK_W-1:0] bank_register_x,
  output reg [BANK_W-1:0] bank_register_y,
  output reg [7:0] port3_and_wait_control,
  output wire [1:0] wait_mode_field
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_T1 = 3'd1;
  localparam [2:0] ST_T2 = 3'd2;
  localparam [2:0] ST_W1 = 3'd3;
  localparam [2:0] ST_W2 = 3'd4;

  wire state_end;
  reg [2:0] bstate;
  reg [1:0] cur_kind;
  reg cur_ext;
  reg cur_reg;
  reg cur_last;
  reg cur_int;
  reg cur_int_end;
  reg [19:0] cur_addr;
  reg [7:0] cur_wdata;
  reg int_active;
  reg [3:0] int_step;
  reg [7:0] int_vec;
  reg samp_irq;
  reg samp_nmi;
  reg nmi_window;

  cbs_state_gen u_state_gen (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .state_end(state_end)
  );

  assign wait_mode_field = port3_and_wait_control[`CBS_WAIT_MSB:`CBS_WAIT_LSB];

  function is_internal_addr;
    input [19:0] a;
    input internal;
    begin
      is_internal_addr = internal || (a[15:0] == `CBS_PORT3_WAIT_ADDR);
    end
  endfunction

  wire wait_seen = cur_ext && !wait_req_n && (wait_mode_field != `CBS_WAIT_NONE);
  wire wait_more = wait_seen && (wait_mode_field == `CBS_WAIT_NORMAL);
  wire finishing = (bstate == ST_T2 && !wait_seen) || (bstate == ST_W2 && !wait_more);
  wire int_done_now = finishing && cur_int_end;

  wire take_int = finishing && cur_last && !cur_int &&
                  (samp_nmi || (samp_irq && interrupt_enable_flag));
  wire halt_wake_int = halted && bstate == ST_IDLE &&
                       (nmi_req || (irq_req && interrupt_enable_flag));
  wire int_src = int_active || take_int;
  wire slot_free = bstate == ST_IDLE || finishing;
  assign cyc_ready = state_end && slot_free && !int_src && !halted && !halt_pulse;
  wire core_launch = cyc_valid && cyc_ready;
  wire int_launch = state_end && slot_free && int_src && !int_done_now;
  wire launch = core_launch || int_launch;

  // next cycle contents, from the core or from the interrupt steps
  reg [1:0] next_kind;
  reg [19:0] next_addr;
  reg [7:0] next_wdata;
  reg next_ext;
  reg next_show_addr;
  reg [15:0] push_addr;
  always @* begin
    next_kind = cyc_kind;
    next_addr = cyc_addr;
    next_wdata = cyc_wdata;
    push_addr = sp_in - {12'h000, int_step - `CBS_INT_STEP_VECTOR - 4'h1};
    if (int_launch) begin
      next_wdata = 8'h00;
      case (take_int ? 4'h0 : int_step)
        4'h0: begin
          next_kind = `CBS_KIND_READ_DISCARD;
          next_addr = {4'h0, pc};
        end
        `CBS_INT_STEP_VECTOR: begin
          next_kind = `CBS_KIND_DUMMY;
          next_addr = {`CBS_VEC_UPPER, int_vec};
        end
        `CBS_INT_STEP_PUSH_PCH: begin
          next_kind = `CBS_KIND_WRITE;
          next_addr = {4'h0, push_addr};
          next_wdata = pc[15:8];
        end
        `CBS_INT_STEP_PUSH_PCL: begin
          next_kind = `CBS_KIND_WRITE;
          next_addr = {4'h0, push_addr};
          next_wdata = pc[7:0];
        end
        `CBS_INT_STEP_PUSH_A: begin
          next_kind = `CBS_KIND_WRITE;
          next_addr = {4'h0, push_addr};
          next_wdata = af_in[15:8];
        end
        `CBS_INT_STEP_PUSH_F: begin
          next_kind = `CBS_KIND_WRITE;
          next_addr = {4'h0, push_addr};
          next_wdata = af_in[7:0];
          next_wdata[`CBS_IE_FLAG_BIT] = interrupt_enable_flag;
        end
        default: begin
          next_kind = `CBS_KIND_DUMMY;
          next_addr = cur_addr;
        end
      endcase
    end
    next_ext = next_kind != `CBS_KIND_DUMMY &&
               !(!int_launch && is_internal_addr(cyc_addr, cyc_internal));
    next_show_addr = int_launch && !take_int && int_step == `CBS_INT_STEP_VECTOR;
  end

  // bus cycle engine and pins
  always @(posedge core_clk) begin
    if (sys_rst) begin
      bstate <= ST_IDLE;
      cur_kind <= `CBS_KIND_DUMMY;
      cur_ext <= 1'b0;
      cur_reg <= 1'b0;
      cur_last <= 1'b0;
      cur_int <= 1'b0;
      cur_int_end <= 1'b0;
      cur_addr <= 20'h00000;
      cur_wdata <= 8'h00;
      cyc_done <= 1'b0;
      cyc_rdata <= 8'h00;
      ext_addr <= 20'h00000;
      ext_addr_oe <= 1'b0;
      ext_data_out <= 8'h00;
      ext_data_oe <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      bus_clk <= 1'b1;
      port3_and_wait_control <= `CBS_PORT3_RESET;
    end else begin
      cyc_done <= 1'b0;
      if (state_end) begin
        case (bstate)
          ST_T1: begin
            bstate <= ST_T2;
            bus_clk <= 1'b0;
          end
          ST_T2, ST_W2: begin
            if (!finishing) begin
              bstate <= ST_W1;
              bus_clk <= 1'b1;
            end
          end
          ST_W1: begin
            bstate <= ST_W2;
            bus_clk <= 1'b0;
          end
          default: bstate <= ST_IDLE;
        endcase
        if (finishing) begin
          bstate <= ST_IDLE;
          bus_clk <= 1'b1;
          rd_n <= 1'b1;
          wr_n <= 1'b1;
          ext_addr_oe <= 1'b0;
          ext_data_oe <= 1'b0;
          cyc_done <= !cur_int;
          if (cur_kind == `CBS_KIND_READ) begin
            cyc_rdata <= cur_reg ? port3_and_wait_control : ext_data_in;
          end
          if (cur_kind == `CBS_KIND_WRITE && cur_reg) begin
            port3_and_wait_control <= cur_wdata;
          end
        end
        if (launch) begin
          bstate <= ST_T1;
          bus_clk <= 1'b1;
          cur_kind <= next_kind;
          cur_ext <= next_ext;
          cur_reg <= !int_launch && cyc_addr[15:0] == `CBS_PORT3_WAIT_ADDR;
          cur_last <= core_launch && cyc_last;
          cur_int <= int_launch;
          cur_int_end <= int_launch && !take_int && int_step == `CBS_INT_STEP_PUSH_F;
          cur_addr <= next_addr;
          cur_wdata <= next_wdata;
          ext_addr <= next_addr;
          ext_addr_oe <= next_ext || next_show_addr;
          rd_n <= !(next_ext && next_kind != `CBS_KIND_WRITE);
          wr_n <= !(next_ext && next_kind == `CBS_KIND_WRITE);
          ext_data_out <= next_wdata;
          ext_data_oe <= next_ext && next_kind == `CBS_KIND_WRITE;
        end
      end
    end
  end

  // interrupt acceptance, halt and cpu state held here
  always @(posedge core_clk) begin
    if (sys_rst) begin
      int_active <= 1'b0;
      int_step <= 4'h0;
      int_vec <= 8'h00;
      samp_irq <= 1'b0;
      samp_nmi <= 1'b0;
      nmi_window <= 1'b0;
      halted <= 1'b0;
      irq_accept <= 1'b0;
      interrupt_enable_flag <= 1'b0;
      bank_register_x <= {BANK_W{1'b0}};
      bank_register_y <= {BANK_W{1'b0}};
      pc <= `CBS_PC_RESET;
    end else begin
      irq_accept <= 1'b0;
      nmi_window <= 1'b0;
      if (state_end && bstate == ST_T1 && cur_last && !cur_int) begin
        samp_irq <= irq_req;
        nmi_window <= 1'b1;
      end
      if (nmi_window) begin
        samp_nmi <= nmi_req;
      end
      if (finishing && state_end && cur_last) begin
        samp_irq <= 1'b0;
        samp_nmi <= 1'b0;
      end
      if (bank_load_x) begin
        bank_register_x <= bank_wdata;
      end
      if (bank_load_y) begin
        bank_register_y <= bank_wdata;
      end
      if (pc_load) begin
        pc <= pc_next;
      end
      if (ei_pulse) begin
        interrupt_enable_flag <= 1'b1;
      end
      if (di_pulse) begin
        interrupt_enable_flag <= 1'b0;
      end
      if (halt_pulse) begin
        halted <= 1'b1;
      end
      if (state_end && halted && bstate == ST_IDLE) begin
        if (halt_wake_int) begin
          halted <= 1'b0;
          int_active <= 1'b1;
          int_step <= 4'h0;
        end else if (irq_req) begin
          halted <= 1'b0;
        end
      end
      if (state_end && take_int) begin
        int_active <= 1'b1;
        int_step <= 4'h0;
      end
      if (int_launch) begin
        int_step <= (take_int ? 4'h0 : int_step) + 4'h1;
        if (!take_int && int_step == `CBS_INT_STEP_VEC_LATCH) begin
          int_vec <= irq_vector;
        end
      end
      if (state_end && int_done_now) begin
        int_active <= 1'b0;
        int_step <= 4'h0;
        interrupt_enable_flag <= 1'b0;
        pc <= {8'h00, int_vec};
        irq_accept <= 1'b1;
      end
    end
  end

  // the core requests the byte after the prefetched opcode first
  // the sequencer runs the cycles it is handed plus its own interrupt acknowledge cycles
endmodule
`default_nettype wire

//--- hw/cbs_state_gen.v
// state generator: one state is two core clocks
// assumes core_clk is the oscillator and sys_rst is synchronous
`timescale 1ns/100ps
`default_nettype none
module cbs_state_gen (
  input wire core_clk,
  input wire sys_rst,
  output wire state_end
);
  reg phase;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  assign state_end = phase;
endmodule
`default_nettype wire

//--- shared/cbs_regs.vh
// constants of the cpu bus cycle sequencer: register location, fields, cycle kinds
// assumes the includer sits inside a module and uses the values at the stated widths
`ifndef CBS_REGS_VH
`define CBS_REGS_VH

`define CBS_PORT3_WAIT_ADDR 16'hffc7
`define CBS_PORT3_RESET 8'h00
`define CBS_WAIT_MSB 7
`define CBS_WAIT_LSB 6
`define CBS_WAIT_TWO_STATE 2'b00
`define CBS_WAIT_NORMAL 2'b01
`define CBS_WAIT_NONE 2'b10
`define CBS_IE_FLAG_BIT 5

`define CBS_KIND_READ 2'h0
`define CBS_KIND_READ_DISCARD 2'h1
`define CBS_KIND_WRITE 2'h2
`define CBS_KIND_DUMMY 2'h3

`define CBS_INT_STEP_VEC_LATCH 4'h1
`define CBS_INT_STEP_VECTOR 4'h3
`define CBS_INT_STEP_PUSH_PCH 4'h5
`define CBS_INT_STEP_PUSH_PCL 4'h6
`define CBS_INT_STEP_PUSH_A 4'h7
`define CBS_INT_STEP_PUSH_F 4'h8
`define CBS_VEC_UPPER 12'h000
`define CBS_PC_RESET 16'h0000

`endif

//--- tb/cbs_bus_sequencer_properties.sv
// port assertions for the bus cycle sequencer
// assumes it is bound into cbs_bus_sequencer and sees its ports by name
`timescale 1ns/100ps
`default_nettype none
module cbs_seq_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cyc_valid,
  input wire logic cyc_ready,
  input wire logic [1:0] cyc_kind,
  input wire logic [19:0] cyc_addr,
  input wire logic cyc_internal,
  input wire logic cyc_done,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bus_clk,
  input wire logic ext_addr_oe,
  input wire logic ext_data_oe,
  input wire logic [15:0] pc,
  input wire logic interrupt_enable_flag,
  input wire logic halted,
  input wire logic irq_accept,
  input wire logic [1:0] wait_mode_field,
  input wire logic [19:0] ext_addr,
  input wire logic [7:0] irq_vector,
  input wire logic irq_req,
  input wire logic nmi_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire take = cyc_valid && cyc_ready;
  // the control register decodes on the low 16 bits and never reaches the pins
  wire ext = !cyc_internal && cyc_addr[15:0] != 16'hffc7;

  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
    rd_n && wr_n && bus_clk && !ext_addr_oe && !ext_data_oe) else $error("pins not idle in reset");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
    pc == 16'h0000 && !interrupt_enable_flag && wait_mode_field == 2'b00 && !halted)
    else $error("state not cleared by reset");
  a_nowait_two: assert property (take && wait_mode_field == 2'b10 |-> ##5 cyc_done)
    else $error("no-wait cycle not two states");
  a_dummy_quiet: assert property (take && (cyc_kind == 2'h3 || !ext) |=>
    (rd_n && wr_n) [*4] ##1 cyc_done) else $error("dummy cycle strobed or stretched");
  a_first_wait: assert property (take && ext && cyc_kind != 2'h3 &&
    wait_mode_field == 2'b00 |-> ##5 (cyc_done or ##4 cyc_done)) else $error("two-state wait wrong");
  a_read_strobe: assert property (take && ext && cyc_kind <= 2'h1 |=> !rd_n [*4])
    else $error("read strobe missing");
  a_write_drive: assert property (take && ext && cyc_kind == 2'h2 |=>
    (!wr_n && ext_data_oe) [*4]) else $error("write not driven");
  a_clk_pair: assert property (take |=> bus_clk [*2] ##1 !bus_clk [*2])
    else $error("bus clock out of step");
  a_accept_jump: assert property (irq_accept |->
    !interrupt_enable_flag && pc[15:8] == 8'h00) else $error("bad handler entry");
  a_halt_refuse: assert property (halted |-> !cyc_ready) else $error("request taken in halt");
  // only the vector dummy shows an address with both strobes high
  a_vector_addr: assert property (ext_addr_oe && rd_n && wr_n |->
    ext_addr == {12'h000, irq_vector}) else $error("vector address wrong");
  a_halt_hold: assert property (halted && !irq_req && !nmi_req |=> halted)
    else $error("halt left without request");

  cover property (take && ext && cyc_kind == 2'h2);
  cover property (irq_accept);
  cover property ($fell(halted));
  cover property (ext_addr_oe && rd_n && wr_n);
endmodule
bind cbs_bus_sequencer cbs_seq_props u_props (.*);
`default_nettype wire

//--- tb/cbs_bus_sequencer_test.sv
// self-checking bench for the bus sequencer against an external memory model
// assumes the checker binds itself; inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module cbs_bus_sequencer_test;
  logic core_clk, sys_rst, cyc_valid, cyc_internal, cyc_last, irq_req, nmi_req;
  logic ei_pulse, di_pulse, halt_pulse, pc_load, bank_load_x, bank_load_y;
  logic [1:0] cyc_kind, waits;
  logic [19:0] cyc_addr;
  logic [7:0] cyc_wdata, irq_vector, bank_wdata, d, v;
  logic [15:0] sp_in, af_in, pc_next;
  wire cyc_ready, cyc_done, ext_addr_oe, ext_data_oe, rd_n, wr_n, bus_clk, wait_req_n;
  wire interrupt_enable_flag, halted, irq_accept;
  wire [7:0] cyc_rdata, ext_data_in, ext_data_out, port3_and_wait_control;
  wire [7:0] bank_register_x, bank_register_y;
  wire [19:0] ext_addr;
  wire [15:0] pc;
  wire [1:0] wait_mode_field;
  integer seed = 32, error_cnt = 0, n_checks = 0, n, i, m, w;
  cbs_bus_sequencer uut (.*);
  cbs_ext_mem u_mem (.*);
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  task chk(input logic [19:0] g, e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task lat(input integer e);
    chk(n[19:0], e[19:0]);
  endtask
  // n counts falling edges from the taking edge until done shows
  task cyc(input logic [1:0] k, input logic [19:0] a, input logic [7:0] wd, input logic in);
    cyc_valid = 1;
    {cyc_kind, cyc_addr, cyc_wdata, cyc_internal} = {k, a, wd, in};
    do @(posedge core_clk); while (cyc_ready !== 1'b1);
    @(negedge core_clk);
    cyc_valid = 0;
    n = 1;
    while (cyc_done !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task acc;
    i = 0;
    while (irq_accept !== 1'b1 && i < 200) begin
      @(negedge core_clk);
      i++;
    end
    // nine two-state cycles of four core clocks each; a timeout fails here
    chk(i[19:0], 20'h24);
  endtask
  task pulse_halt;
    halt_pulse = 1;
    @(negedge core_clk);
    halt_pulse = 0;
  endtask
  function integer exp_lat(input integer m, w);
    exp_lat = 5 + 4 * (m == 2 ? 0 : (m == 0 ? (w > 0) : w));
  endfunction
  task results;
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    results;
  end
  initial begin
    {cyc_valid, cyc_internal, cyc_last, irq_req, nmi_req, ei_pulse, di_pulse} = 0;
    {halt_pulse, pc_load, bank_load_x, bank_load_y, waits, cyc_kind} = 0;
    {cyc_addr, cyc_wdata, irq_vector, bank_wdata, sp_in, af_in, pc_next} = 0;
    sys_rst = 1;
    repeat (2) @(negedge core_clk);
    sys_rst = 0;
    chk(port3_and_wait_control, 8'h00);
    chk(pc, 16'h0000);
    chk({rd_n, wr_n, bus_clk}, 3'h7);
    for (m = 0; m < 3; m++) for (w = 0; w < 3; w++) begin
      waits = w[1:0];
      cyc(2'h2, 20'h0ffc7, {m[1:0], 6'h00}, 0);
      lat(5);
      cyc(2'h0, 20'h0ffc7, 8'h00, 0);
      chk(cyc_rdata, {m[1:0], 6'h00});
      d = 8'($random(seed));
      v = 8'($random(seed));
      cyc(2'h2, {12'h001, v}, d, 0);
      lat(exp_lat(m, w));
      cyc(2'h0, {12'h001, v}, 8'h00, 0);
      chk(cyc_rdata, d);
      lat(exp_lat(m, w));
      cyc(2'h1, {12'h001, ~v}, 8'h00, 0);
      chk(cyc_rdata, d);
    end
    // a held wait must not stretch dummy or internal cycles in normal mode
    cyc(2'h2, 20'h0ffc7, 8'h40, 0);
    waits = 2'h3;
    for (i = 0; i < 4; i++) begin
      cyc(i[1:0], {12'h001, v}, d, i != 3);
      lat(5);
    end
    cyc(2'h2, 20'h0ffc7, 8'h80, 0);
    cyc(2'h0, {12'h001, v}, 8'h00, 0);
    lat(5);
    waits = 2'h0;
    pc_next = 16'($random(seed));
    {ei_pulse, pc_load} = 2'h3;
    @(negedge core_clk);
    {ei_pulse, pc_load, di_pulse} = 3'h1;
    chk(interrupt_enable_flag, 1'b1);
    @(negedge core_clk);
    {ei_pulse, di_pulse} = 2'h2;
    chk(interrupt_enable_flag, 1'b0);
    @(negedge core_clk);
    ei_pulse = 0;
    chk(interrupt_enable_flag, 1'b1);
    irq_vector = 8'($random(seed));
    af_in = 16'($random(seed));
    sp_in = 16'h0080;
    irq_req = 1;
    cyc_last = 1;
    cyc(2'h0, 20'h00000, 8'h00, 0);
    cyc_last = 0;
    acc;
    irq_req = 0;
    chk(pc, {8'h00, irq_vector});
    chk(interrupt_enable_flag, 1'b0);
    chk(u_mem.mem[8'h7f], pc_next[15:8]);
    chk(u_mem.mem[8'h7e], pc_next[7:0]);
    chk(u_mem.mem[8'h7d], af_in[15:8]);
    chk(u_mem.mem[8'h7c], af_in[7:0] | 8'h20);
    pulse_halt;
    // no request yet: halt must hold on its own
    repeat (4) @(negedge core_clk);
    chk(halted, 1'b1);
    irq_req = 1;
    repeat (12) @(negedge core_clk);
    irq_req = 0;
    chk({halted, pc}, {1'b0, 8'h00, irq_vector});
    nmi_req = 1;
    cyc_last = 1;
    irq_vector = irq_vector + 8'h08;
    cyc(2'h0, 20'h00000, 8'h00, 0);
    cyc_last = 0;
    acc;
    nmi_req = 0;
    chk(pc, {8'h00, irq_vector});
    bank_wdata = 8'($random(seed));
    {bank_load_x, bank_load_y, ei_pulse} = 3'h7;
    @(negedge core_clk);
    {bank_load_x, bank_load_y, ei_pulse} = 3'h0;
    chk({bank_register_x, bank_register_y}, {bank_wdata, bank_wdata});
    pulse_halt;
    sys_rst = 1;
    repeat (20) @(negedge core_clk);
    sys_rst = 0;
    chk({pc, interrupt_enable_flag, halted}, 18'h0);
    chk({bank_register_x, bank_register_y}, 16'h0);
    chk(port3_and_wait_control, 8'h00);
    results;
  end
endmodule
`default_nettype wire

//--- tb/cbs_ext_mem.sv
// external byte memory on the address/data pins, with wait requests
// assumes strobes stay low for a whole cycle; waits = pairs asked, 3 = held low
`timescale 1ns/100ps
`default_nettype none
module cbs_ext_mem (
  input wire logic core_clk,
  input wire logic [19:0] ext_addr,
  input wire logic [7:0] ext_data_out,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] waits,
  output logic [7:0] ext_data_in,
  output logic wait_req_n
);
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  logic [5:0] cnt = 6'h00;
  // a released bus shows the inverse of its last value, never a stale copy
  assign ext_data_in = !rd_n ? mem[ext_addr[7:0]] : ~last;
  assign wait_req_n = !(waits == 2'h3 || ((!rd_n || !wr_n) && cnt < {2'b00, waits, 2'b00}));
  always @(posedge core_clk) begin
    cnt <= (!rd_n || !wr_n) ? cnt + 6'h01 : 6'h00;
    if (!rd_n) last <= mem[ext_addr[7:0]];
    if (!wr_n) mem[ext_addr[7:0]] <= ext_data_out;
  end
endmodule
`default_nettype wire
